//--- adc_serial_port.sv
// serial port, ready signalling and register routing of the converter
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`include "adc_serial_port_map.svh"

module adc_serial_port #(
  parameter int CONV_CYCLES = `CONV_CYCLES
) (
  input  wire logic                               clk_sys,
  input  wire logic                               rst,
  input  wire logic                               clk_en,
  input  wire logic                               sclk,
  input  wire logic                               cs_n,
  input  wire logic                               din,
  output logic                                    dout,
  output logic                                    dout_oe_n,
  input  wire logic [15:0]                        conv_data,
  input  wire logic [4:0]                         avs_address,
  input  wire logic                               avs_read,
  input  wire logic                               avs_write,
  input  wire logic [31:0]                        avs_writedata,
  output logic      [31:0]                        avs_readdata,
  output logic                                    avs_waitrequest,
  output logic                                    irq,
  output adc_serial_port_pkg::link_state_t        link_state
);
  import adc_serial_port_pkg::*;

  localparam logic [19:0] CONV_LAST = 20'(CONV_CYCLES - 1);
  localparam logic [19:0] LEAD_AT   = 20'(CONV_CYCLES - 1 - `RDY_LEAD_CYCLES);

  // pin synchronisers; stage 0 feeds stage 1 only
  logic [1:0]  sclk_sy_q;
  logic [1:0]  cs_sy_q;
  logic [1:0]  din_sy_q;
  logic        sclk_d_q;

  link_state_t state_q;
  link_state_t state_d;
  logic [4:0]  bitcnt_q;
  logic [4:0]  len_q;
  logic [5:0]  ones_q;
  logic [15:0] isr_q;
  logic [15:0] osr_q;
  reg_sel_t    rs_q;
  logic        cread_q;
  logic        out_act_q;
  logic [7:0]  mode_q;
  logic [7:0]  filt_q;
  logic [15:0] data_q;
  logic        rdy_n_q;
  logic        dout_q;
  logic        oe_n_q;
  logic [19:0] conv_cnt_q;
  logic        conv_en_q;
  logic        ack_q;
  logic [2:0]  sts_q;
  logic [2:0]  mask_q;
  logic [31:0] rdata_q;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      // serial clock idles high; starting there avoids a false edge
      sclk_sy_q <= 2'h3;
      cs_sy_q   <= 2'h3;
      din_sy_q  <= 2'h0;
      sclk_d_q  <= 1'b1;
    end
    else if (clk_en)
    begin
      sclk_sy_q <= {sclk_sy_q[0], sclk};
      cs_sy_q   <= {cs_sy_q[0], cs_n};
      din_sy_q  <= {din_sy_q[0], din};
      sclk_d_q  <= sclk_sy_q[1];
    end
  end

  wire sclk_s = sclk_sy_q[1];
  wire cs_s   = cs_sy_q[1];
  wire din_s  = din_sy_q[1];
  // no chip select edge is needed, so a grounded select works too
  wire sclk_rise = sclk_s & ~sclk_d_q & ~cs_s;
  wire sclk_fall = ~sclk_s & sclk_d_q & ~cs_s;

  wire       in_xfer  = (state_q == ST_WR) || (state_q == ST_RD);
  wire       cmd_last = (state_q == ST_CMDBITS) && sclk_rise &&
                        (bitcnt_q == `CMD_BITS - 5'd1);
  wire [7:0] cmd_byte = {1'b0, isr_q[5:0], din_s};
  wire       cmd_rw   = cmd_byte[`CMD_RW];
  reg_sel_t  cmd_rs;
  assign cmd_rs = cmd_byte[`CMD_RS_HI:`CMD_RS_LO];
  wire       xfer_last = in_xfer && sclk_rise && (bitcnt_q == len_q - 5'd1);
  wire [15:0] in_word  = {isr_q[14:0], din_s};
  wire       ones_hit  = sclk_rise && din_s &&
                         (ones_q == `ONES_LIMIT - 6'd1);
  wire       rd_fall   = (state_q == ST_RD) && sclk_fall;
  wire       rd_done   = (state_q == ST_RD) && xfer_last &&
                         (rs_q == `RS_DATA);
  wire       wr_done   = (state_q == ST_WR) && xfer_last;
  wire       stay_cread = cread_q && (rs_q == `RS_DATA);

  wire conv_tick = conv_en_q && (conv_cnt_q == CONV_LAST);
  wire lead_tick = conv_en_q && (conv_cnt_q == LEAD_AT);
  // next ready level; the pin follows it with no stale cycle after a read
  wire rdy_n_nx  = ones_hit |
                   (~conv_tick & (rdy_n_q | lead_tick | rd_done));

  // any register can be shifted out; 8-bit ones sit in the top byte
  wire [15:0] rd_word = (cmd_rs == `RS_COMM) ?
                          {rdy_n_q, `STATUS_LOW, 8'h00} :
                        (cmd_rs == `RS_MODE) ? {mode_q, 8'h00} :
                        (cmd_rs == `RS_FILT) ? {filt_q, 8'h00} : data_q;
  wire [4:0]  cmd_len = (cmd_rs == `RS_DATA) ? `WORD_BITS : `BYTE_BITS;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_CMD:
        if (sclk_rise && !din_s)
          state_d = ST_CMDBITS;
      ST_CMDBITS:
        if (cmd_last)
        begin
          if (cmd_rw)
            state_d = ST_RD;
          else if (cmd_rs == `RS_COMM)
            state_d = ST_CMD;
          else
            state_d = ST_WR;
        end
      ST_WR:
        if (xfer_last)
          state_d = ST_CMD;
      ST_RD:
        if (xfer_last)
          state_d = stay_cread ? ST_RD : ST_CMD;
      default:
        state_d = ST_CMD;
    endcase
    if (ones_hit)
      state_d = ST_CMD;
  end

  // serial state is held between clock bursts, any gap length works
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q  <= ST_CMD;
      bitcnt_q <= 5'h0;
      ones_q   <= 6'h0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      if (ones_hit || cmd_last || xfer_last)
        bitcnt_q <= 5'h0;
      else if (sclk_rise && state_q != ST_CMD)
        bitcnt_q <= bitcnt_q + 5'd1;
      if (ones_hit)
        ones_q <= 6'h0;
      else if (sclk_rise)
        ones_q <= din_s ? ones_q + 6'd1 : 6'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      isr_q   <= 16'h0;
      rs_q    <= `RS_COMM;
      cread_q <= 1'b0;
      len_q   <= `BYTE_BITS;
    end
    else if (clk_en)
    begin
      if (sclk_rise)
        isr_q <= in_word;
      if (ones_hit)
        cread_q <= 1'b0;
      else if (cmd_last)
      begin
        rs_q    <= cmd_rs;
        len_q   <= cmd_len;
        cread_q <= cmd_rw && cmd_byte[`CMD_CREAD];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= `MODE_RST;
      filt_q <= `FILT_RST;
    end
    else if (clk_en)
    begin
      if (ones_hit)
      begin
        mode_q <= `MODE_RST;
        filt_q <= `FILT_RST;
      end
      else if (wr_done && rs_q == `RS_MODE)
        mode_q <= in_word[7:0];
      else if (wr_done && rs_q == `RS_FILT)
        filt_q <= in_word[7:0];
    end
  end

  // continuous read reloads the shifter from each new result that arrives while no read is shifting out
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      osr_q <= 16'h0;
    else if (clk_en)
    begin
      if (cmd_last && cmd_rw)
        osr_q <= rd_word;
      else if (rd_fall)
        osr_q <= {osr_q[14:0], 1'b0};
      else if (conv_tick && stay_cread && !out_act_q)
        osr_q <= conv_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      conv_cnt_q <= 20'h0;
      data_q     <= `DATA_RST;
      rdy_n_q    <= 1'(`STATUS_RST >> 7);
    end
    else if (clk_en)
    begin
      if (ones_hit)
      begin
        conv_cnt_q <= 20'h0;
        data_q     <= `DATA_RST;
        rdy_n_q    <= 1'b1;
      end
      else
      begin
        if (conv_en_q)
          conv_cnt_q <= conv_tick ? 20'h0 : conv_cnt_q + 20'd1;
        if (conv_tick)
        begin
          data_q  <= conv_data;
          rdy_n_q <= 1'b0;
        end
        else if (lead_tick || rd_done)
          rdy_n_q <= 1'b1;
      end
    end
  end

  // the pin shows ready until a read's first falling edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      out_act_q <= 1'b0;
      dout_q    <= 1'b1;
      oe_n_q    <= 1'b1;
    end
    else if (clk_en)
    begin
      oe_n_q <= cs_s;
      if (rd_fall)
        out_act_q <= 1'b1;
      else if (xfer_last || ones_hit)
        out_act_q <= 1'b0;
      if (rd_fall)
        dout_q <= osr_q[15];
      else if (!out_act_q || xfer_last)
        dout_q <= rdy_n_nx;
    end
  end

  assign dout       = dout_q;
  assign dout_oe_n  = oe_n_q;
  assign link_state = state_q;

  // bus slave: one wait cycle, answer on the second cycle
  wire        av_req  = avs_read | avs_write;
  wire        wr_go   = avs_write & ack_q;
  wire        sel_ctl = (avs_address == `AV_CTRL);
  wire        sel_sts = (avs_address == `AV_STATUS);
  wire        sel_msk = (avs_address == `AV_MASK);
  wire [2:0]  sts_clr = (wr_go && sel_sts) ? avs_writedata[2:0] : 3'h0;
  wire [2:0]  sts_set = {ones_hit, rd_done, conv_tick};
  logic [31:0] rd_mux;

  always_comb
  begin
    if (avs_address == `AV_CTRL)
      rd_mux = {31'h0, conv_en_q};
    else if (avs_address == `AV_STATUS)
      rd_mux = {29'h0, sts_q};
    else if (avs_address == `AV_MASK)
      rd_mux = {29'h0, mask_q};
    else if (avs_address == `AV_REGS)
      rd_mux = {15'h0, rdy_n_q, filt_q, mode_q};
    else if (avs_address == `AV_DATA)
      rd_mux = {16'h0, data_q};
    else
      rd_mux = 32'h0;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ack_q     <= 1'b0;
      rdata_q   <= 32'h0;
      conv_en_q <= `CTRL_RST;
      sts_q     <= 3'h0;
      mask_q    <= 3'h0;
    end
    else if (clk_en)
    begin
      ack_q <= av_req & ~ack_q;
      if (avs_read && !ack_q)
        rdata_q <= rd_mux;
      if (wr_go && sel_ctl)
        conv_en_q <= avs_writedata[0];
      if (wr_go && sel_msk)
        mask_q <= avs_writedata[2:0];
      // a new event wins over a clear in the same cycle
      sts_q <= (sts_q & ~sts_clr) | sts_set;
    end
  end

  assign avs_waitrequest = av_req & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign irq             = |(sts_q & mask_q);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !clk_en);

  sequence seq_data_read_end;
    rd_done && !conv_tick && !ones_hit;
  endsequence

  sequence seq_mode_write_end;
    wr_done && rs_q == `RS_MODE && !ones_hit;
  endsequence

  chk_hiz_deselect: assert property (
    cs_s |=> dout_oe_n)
    else $error("output driven while deselected");

  chk_rdy_on_conv: assert property (
    conv_tick && !ones_hit |=> !rdy_n_q ##0 sts_q[0])
    else $error("ready not signalled after conversion");

  chk_rdy_lead: assert property (
    lead_tick && !ones_hit |=> rdy_n_q [*8])
    else $error("ready not raised ahead of update");

  chk_out_falling: assert property (
    rd_fall |=> dout == $past(osr_q[15]) && !dout_oe_n)
    else $error("output bit not placed on falling edge");

  chk_capture_rise: assert property (
    sclk_rise |=> isr_q[0] == $past(din_s))
    else $error("input bit not captured on rising edge");

  chk_wen_gate: assert property (
    state_q == ST_CMD && sclk_rise && din_s |=> state_q == ST_CMD)
    else $error("command started without zero gate bit");

  chk_ones_reset: assert property (
    ones_hit |=> state_q == ST_CMD && mode_q == `MODE_RST && rdy_n_q)
    else $error("thirty-two ones did not reset the port");

  chk_read_clears: assert property (
    seq_data_read_end |=> rdy_n_q && dout == 1'b1)
    else $error("ready not raised after result read");

  chk_write_route: assert property (
    seq_mode_write_end |=> mode_q == $past(in_word[7:0]) &&
                           state_q == ST_CMD)
    else $error("written byte not routed to mode register");

  chk_load_any: assert property (
    cmd_last && cmd_rw && !ones_hit |=> state_q == ST_RD &&
                                        osr_q == $past(rd_word))
    else $error("output shifter not loaded from selected register");

endmodule : adc_serial_port

//--- adc_serial_port_map.svh
// offsets, field positions, reset values and timing counts of the port
// Function
// - Serial clock continuous or in separate bursts
// - Active-low chip select addresses or frames transfers
// - Works with chip select tied low
// - Ready line falls when a conversion finishes
// - Unread result: ready line rises before update
// - Output bits change on falling clock edge
// - Status flag also reports end of conversion
// - Output floats while deselected, flag keeps tracking
// - Output shifter loads from any internal register
// - Input shifter moves into register picked by select
// - Every access starts with a command byte; here continuous reads after the first take none
// - Thirty-two high input bits reset the part
// - Command byte waits for a zero gate bit
// - Ready rises after result read, after each one in continuous
`ifndef ADC_SERIAL_PORT_MAP_SVH
`define ADC_SERIAL_PORT_MAP_SVH

`define AV_CTRL        5'h00
`define AV_STATUS      5'h04
`define AV_MASK        5'h08
`define AV_REGS        5'h0c
`define AV_DATA        5'h10

`define CMD_RS_HI      5
`define CMD_RS_LO      4
`define CMD_RW         3
`define CMD_CREAD      2

`define RS_COMM        2'h0
`define RS_MODE        2'h1
`define RS_FILT        2'h2
`define RS_DATA        2'h3

`define STATUS_RST     8'h88
`define STATUS_LOW     7'h08
`define MODE_RST       8'h02
`define FILT_RST       8'h04
`define DATA_RST       16'h0000
`define CTRL_RST       1'b1

`define CMD_BITS       5'd7
`define BYTE_BITS      5'd8
`define WORD_BITS      5'd16
`define ONES_LIMIT     6'd32

`define CLK_MHZ        50
`define CONV_PERIOD_US 1000
`define CONV_CYCLES    (`CONV_PERIOD_US * `CLK_MHZ)
`define RDY_LEAD_NS    2000
`define RDY_LEAD_CYCLES ((`RDY_LEAD_NS * `CLK_MHZ + 999) / 1000)

`endif

//--- adc_serial_port_pkg.sv
// types shared by the serial port and its users
package adc_serial_port_pkg;

  typedef enum logic [1:0] {
    ST_CMD,
    ST_CMDBITS,
    ST_WR,
    ST_RD
  } link_state_t;

  typedef logic [1:0] reg_sel_t;

endpackage : adc_serial_port_pkg

//--- serial_host.sv
// host side serial master model: clock, select and data in
`timescale 1ns/1ns

module serial_host (
  input  wire logic clk_sys,
  input  wire logic dout,
  input  wire logic dout_oe_n,
  output logic      sclk,
  output logic      cs_n,
  output logic      din
);
  logic three_wire;
  logic ready_seen;
  logic dout_seen;

  // a released line has no pull-up here, so it reads as the inverse
  assign dout_seen = dout_oe_n ? ~dout : dout;

  // the host takes a falling ready as its result interrupt
  always @(negedge dout_seen)
    if (dout_oe_n === 1'b0)
      ready_seen <= 1'b1;

  // clock idles high and stands still outside frames
  initial
  begin
    sclk       = 1'b1;
    cs_n       = 1'b1;
    din        = 1'b1;
    three_wire = 1'b0;
    ready_seen = 1'b0;
  end

  // four system clocks per half period gives 160 ns serial clock
  task automatic half_wait;
    repeat (4) @(posedge clk_sys);
  endtask : half_wait

  // msb first; gap idles the clock between bytes
  task automatic xfer(input logic [31:0] tx, input int nbits,
                      input int gap, output logic [31:0] rx);
    rx = '0;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    half_wait();
    for (int i = nbits - 1; i >= 0; i--)
    begin
      sclk <= 1'b0;
      din  <= tx[i];
      half_wait();
      sclk <= 1'b1;
      // sampled with the rise; the bit was launched on the fall before
      rx = {rx[30:0], dout_seen};
      half_wait();
      if (gap > 0 && i % 8 == 0 && i > 0)
        repeat (gap) @(posedge clk_sys);
    end
    if (!three_wire)
      cs_n <= 1'b1;
    din <= ~din;
    half_wait();
  endtask : xfer

  task automatic deselect;
    three_wire = 1'b0;
    cs_n <= 1'b1;
    @(posedge clk_sys);
  endtask : deselect
endmodule : serial_host

//--- adc_serial_port_tb.sv
// self-checking bench of the converter serial port
`timescale 1ns/1ns
`include "adc_serial_port_map.svh"

module adc_serial_port_tb;
  import adc_serial_port_pkg::*;

  logic        clk_sys, rst, clk_en, sclk, cs_n, din;
  logic        dout, dout_oe_n, irq, avs_read, avs_write;
  logic        avs_waitrequest;
  logic [15:0] conv_data;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  link_state_t link_state;
  int          fail_count, n_tests;

  adc_serial_port #(.CONV_CYCLES(400)) adc_serial_port_i (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
    .conv_data(conv_data), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq),
    .link_state(link_state));

  serial_host serial_host_i (
    .clk_sys(clk_sys), .dout(dout), .dout_oe_n(dout_oe_n),
    .sclk(sclk), .cs_n(cs_n), .din(din));

  task automatic conclude;
    $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // called just after a rising edge; holds until waitrequest is low
  task automatic av(input logic wr, input logic [4:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    @(posedge clk_sys);
    for (n = 0; n < 50 && avs_waitrequest !== 1'b0; n++)
      @(posedge clk_sys);
    if (n == 50)
    begin
      fail_count++;
      conclude();
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge, so a next call never re-raises in this time step
    @(posedge clk_sys);
  endtask : av

  task automatic wait_irq;
    int n;
    for (n = 0; n < 1000; n++)
    begin
      @(posedge clk_sys);
      if (irq === 1'b1)
        break;
    end
    if (n == 1000)
    begin
      fail_count++;
      conclude();
    end
  endtask : wait_irq

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    conclude();
  end

  initial
  begin
    fail_count    = 0;
    n_tests       = 0;
    rst           = 1'b1;
    clk_en        = 1'b1;
    conv_data     = 16'hc35a;
    avs_address   = 5'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk(dout_oe_n, 1'b1);
    av(0, `AV_REGS, 0, rd);
    chk(rd, 32'h0001_0402);
    av(0, 5'h14, 0, rd);
    chk(rd, 32'h0);
    av(1, `AV_MASK, 32'h7, rd);
    av(0, `AV_MASK, 0, rd);
    chk(rd, 32'h7);
    // ones before the gate bit are skipped, bytes sent in bursts
    serial_host_i.xfer(32'h00ff_105a, 24, 6, rd);
    chk(link_state, ST_CMD);
    av(0, `AV_REGS, 0, rd);
    chk(rd & 32'hffff, 32'h045a);
    serial_host_i.xfer(32'h1800, 16, 0, rd);
    chk(rd & 32'hff, 32'h5a);
    // select stays low until the deselect at the end
    serial_host_i.three_wire = 1'b1;
    serial_host_i.xfer(32'hff, 8, 0, rd);
    av(1, `AV_STATUS, 32'h7, rd);
    wait_irq();
    repeat (2) @(posedge clk_sys);
    chk({dout_oe_n, dout}, 2'b00);
    av(0, `AV_STATUS, 0, rd);
    chk(rd & 32'h1, 32'h1);
    serial_host_i.xfer(32'h38_0000, 24, 0, rd);
    chk(rd & 32'hffff, 32'hc35a);
    repeat (8) @(posedge clk_sys);
    chk(dout, 1'b1);
    serial_host_i.ready_seen = 1'b0;
    av(0, `AV_STATUS, 0, rd);
    chk(rd & 32'h2, 32'h2);
    av(1, `AV_STATUS, 32'h7, rd);
    wait_irq();
    repeat (290) @(posedge clk_sys);
    chk(dout, 1'b0);
    chk(serial_host_i.ready_seen, 1'b1);
    repeat (20) @(posedge clk_sys);
    chk(dout, 1'b1);
    av(1, `AV_CTRL, 0, rd);
    av(1, `AV_MASK, 0, rd);
    av(0, `AV_STATUS, 0, rd);
    chk(rd & 32'h1, 32'h1);
    chk(irq, 1'b0);
    av(1, `AV_STATUS, 32'h7, rd);
    av(0, `AV_STATUS, 0, rd);
    chk(rd, 32'h0);
    av(1, `AV_MASK, 32'h7, rd);
    chk(irq, 1'b0);
    serial_host_i.xfer(32'h2033, 16, 0, rd);
    av(0, `AV_REGS, 0, rd);
    chk(rd & 32'hffff, 32'h335a);
    // continuous read: the data command stays open for each new result
    serial_host_i.xfer(32'h3c_0000, 24, 0, rd);
    chk(rd & 32'hffff, 32'hc35a);
    chk(link_state, ST_RD);
    conv_data <= 16'h3ca5;
    av(1, `AV_STATUS, 32'h7, rd);
    av(1, `AV_CTRL, 32'h1, rd);
    wait_irq();
    serial_host_i.xfer(32'h0, 16, 0, rd);
    chk(rd & 32'hffff, 32'h3ca5);
    av(1, `AV_CTRL, 0, rd);
    serial_host_i.xfer(32'hffff_ffff, 32, 0, rd);
    repeat (8) @(posedge clk_sys);
    av(0, `AV_REGS, 0, rd);
    chk(rd & 32'hffff, 32'h0402);
    av(0, `AV_STATUS, 0, rd);
    chk(rd & 32'h4, 32'h4);
    chk(irq, 1'b1);
    chk(link_state, ST_CMD);
    serial_host_i.deselect();
    repeat (6) @(posedge clk_sys);
    chk(dout_oe_n, 1'b1);
    conclude();
  end
endmodule : adc_serial_port_tb
